// ===== design/qual_match.sv
// range comparator for one qualifier term against one bus state
// assumes the state and bounds are stable within the clock cycle
`timescale 1ns/1ps
`default_nettype none
module qual_match import ttq_pkg::*; (
   input wire state_s st, // state under test
   input wire qual_s q, // bounds of this term
   output logic hit // state lies inside every field range
);
   // a single value is simply a range whose bounds are equal
   function automatic logic in_range(input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   state_s lo_b; // low bounds seen as fields
   state_s hi_b; // high bounds seen as fields
   assign lo_b = state_s'(q.lo);
   assign hi_b = state_s'(q.hi);

   // all three fields must be in range
   assign hit = in_range(st.addr, lo_b.addr, hi_b.addr) &&
                in_range({8'h00, st.data}, {8'h00, lo_b.data},
                         {8'h00, hi_b.data}) &&
                in_range({8'h00, st.status}, {8'h00, lo_b.status},
                         {8'h00, hi_b.status});
endmodule
`default_nettype wire

// ===== design/trace_trigger_window_qualifier.sv
// trace trigger, storage and window qualifier with trace memory
// assumes an avalon-mm master and a bus state strobe, both on clock
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ttq_defines.svh"
module trace_trigger_window_qualifier import ttq_pkg::*; (
   input wire logic clock, // 20 MHz system clock
   input wire logic nrst, // asynchronous reset, active low
   input wire logic [7:0] address, // avalon byte address
   input wire logic read, // avalon read request
   input wire logic write, // avalon write request
   input wire logic [3:0] byteenable, // avalon byte lanes
   input wire logic [31:0] writedata, // avalon write data
   output logic [31:0] readdata, // avalon read data
   output logic waitrequest, // avalon stall
   input wire logic state_valid, // one-cycle strobe per bus state
   input wire state_s state_in, // traced bus state
   output logic triggered, // trigger found in this trace
   output logic complete // trace record finished
);
   localparam int NQ = `NUM_TERMS;

   // merge write data into a register under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // qualifier slot decode, used by both read and write paths
   function automatic logic is_qual(input logic [7:0] a);
      is_qual = (a >= `OFS_QUAL) && (a < `OFS_QUAL + 8'(NQ * 8));
   endfunction

   logic ack; // answer cycle of a bus request
   logic [7:0] qoff; // byte offset inside the qualifier block
   logic [3:0] qsel; // qualifier slot addressed
   logic take_wr; // write takes effect this edge
   logic start; // software starts a trace
   mode_e mode; // trigger placement
   logic win_en; // windowing programmed
   logic [2:0] seq_cfg; // requested sequence terms before trigger
   logic [15:0] occ_target; // occurrences needed to trigger
   qual_s qual [NQ]; // all qualifier terms
   logic [`MEM_AW-1:0] midx; // trace memory read index
   logic [31:0] mem [`MEM_DEPTH]; // trace memory
   logic [`MEM_AW-1:0] ptr; // next write slot
   logic wrapped; // memory has wrapped at least once
   logic [`MEM_AW:0] post_cnt; // states stored since the trigger
   logic [2:0] stage; // sequence terms passed
   logic [15:0] occ_cnt; // trigger qualifier matches so far
   logic win_on; // window in enabled condition
   acq_e fsm; // acquisition state
   logic [NQ-1:0] hit; // per-term match
   logic [2:0] nseq; // sequence terms in force
   logic running; // acquisition in progress
   logic win_eff; // window enabled or windowing off
   logic act; // this state is recognised at all
   logic [3:0] seq_idx; // slot of the term awaited
   logic seq_hit; // awaited sequence term matched
   logic trig_cand; // trigger qualifier matched in place
   logic [15:0] occ_need; // matches needed, never zero
   logic trig_now; // trigger fires on this state
   logic store_ok; // storage qualifier allows this state
   logic do_store; // write this state to memory
   logic [`MEM_AW:0] post_lim; // stores after trigger to finish
   logic post_end; // last store of the record
   logic [31:0] ctrl_rd; // control readback
   logic [31:0] stat_rd; // status readback

   // bus decode
   assign qoff = address - `OFS_QUAL;
   assign qsel = qoff[6:3];
   assign take_wr = ack && write;
   assign start = take_wr && (address == `OFS_CTRL) && byteenable[0] &&
                  writedata[`CTRL_START];

   // one wait cycle per request keeps read data registered
   assign waitrequest = (read || write) && !ack;

   // one comparator per term, enable and disable on their own
   generate
      for (genvar g = 0; g < NQ; g++) begin : g_term
         qual_match u_match (
            .st(state_in),
            .q(qual[g]),
            .hit(hit[g])
         );
      end
   endgenerate

   // sequence length is clamped harder while windowing is on
   always_comb begin
      if (win_en) begin
         nseq = (seq_cfg > `SEQ_MAX_WIN) ? `SEQ_MAX_WIN : seq_cfg;
      end else begin
         nseq = (seq_cfg > `SEQ_MAX) ? `SEQ_MAX : seq_cfg;
      end
   end

   assign running = (fsm == S_PRE) || (fsm == S_POST);
   assign win_eff = !win_en || win_on;
   // a disabling state is itself neither stored nor recognised
   assign act = state_valid && running && win_eff &&
                !(win_en && win_on && hit[`TERM_DIS]);
   assign seq_idx = 4'(`TERM_SEQ0) + {1'b0, stage};
   assign seq_hit = (stage < nseq) && hit[seq_idx];
   assign trig_cand = act && (fsm == S_PRE) && (stage == nseq) &&
                      hit[`TERM_TRIG];
   assign occ_need = (occ_target == 16'h0000) ? 16'h0001 : occ_target;
   assign trig_now = trig_cand && (occ_cnt + 16'h0001 == occ_need);
   assign store_ok = act && hit[`TERM_STORE];

   // what gets written in each phase decides trigger placement
   always_comb begin
      do_store = 1'b0;
      if (fsm == S_PRE) begin
         // after: nothing before trigger; about/before: ring buffer
         do_store = trig_now ||
                    (store_ok && mode != MODE_AFTER);
      end else if (fsm == S_POST) begin
         do_store = store_ok;
      end
   end

   // centered keeps half a memory after the trigger
   assign post_lim = (mode == MODE_ABOUT) ? (`MEM_AW+1)'(`MEM_DEPTH / 2) :
                     (`MEM_AW+1)'(`MEM_DEPTH);
   assign post_end = do_store && (post_cnt + 1'b1 == post_lim);

   // control, occurrence and index registers: software steers mode, window, sequence, occurrence target and memory index
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode <= MODE_AFTER;
         win_en <= 1'b0;
         seq_cfg <= 3'h0;
         occ_target <= `RST_OCC;
         midx <= '0;
      end else if (take_wr) begin
         if (address == `OFS_CTRL && byteenable[0]) begin
            mode <= mode_e'(writedata[`CTRL_MODE_LSB +: 2]);
            win_en <= writedata[`CTRL_WIN];
            seq_cfg <= writedata[`CTRL_SEQ_LSB +: 3];
         end
         if (address == `OFS_OCC) begin
            // a function result cannot be part-selected, so cast it
            occ_target <= 16'(merge({16'h0000, occ_target}, writedata,
                                    byteenable));
         end
         if (address == `OFS_MIDX && byteenable[0]) begin
            midx <= writedata[`MEM_AW-1:0];
         end
      end
   end

   // qualifier terms, each low or high bound one word
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NQ; i++) begin
            qual[i].lo <= `RST_QLO;
            qual[i].hi <= `RST_QHI;
         end
      end else if (take_wr && is_qual(address)) begin
         if (qoff[2]) begin
            qual[qsel].hi <= merge(qual[qsel].hi, writedata, byteenable);
         end else begin
            qual[qsel].lo <= merge(qual[qsel].lo, writedata, byteenable);
         end
      end
   end

   assign ctrl_rd = {25'h0, seq_cfg, win_en, mode, 1'b0};
   assign stat_rd = {18'h0, ptr, stage, wrapped, win_eff, complete,
                     triggered, running};

   // bus answer: ack for one cycle, read data registered with it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ack <= 1'b0;
         readdata <= 32'h00000000;
      end else begin
         ack <= (read || write) && !ack;
         if (read && !ack) begin
            // unmapped addresses read as zero
            if (address == `OFS_CTRL) begin
               readdata <= ctrl_rd;
            end else if (address == `OFS_OCC) begin
               readdata <= {16'h0000, occ_target};
            end else if (address == `OFS_STAT) begin
               readdata <= stat_rd;
            end else if (address == `OFS_MIDX) begin
               readdata <= {26'h0, midx};
            end else if (address == `OFS_MDATA) begin
               readdata <= mem[midx];
            end else if (is_qual(address)) begin
               readdata <= qoff[2] ? qual[qsel].hi : qual[qsel].lo;
            end else begin
               readdata <= 32'h00000000;
            end
         end
      end
   end

   // window condition: only the enable term counts while off
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         win_on <= 1'b0;
      end else if (start) begin
         win_on <= 1'b0;
      end else if (running && state_valid && win_en) begin
         if (!win_on && hit[`TERM_EN]) begin
            win_on <= 1'b1;
         end else if (win_on && hit[`TERM_DIS]) begin
            win_on <= 1'b0;
         end
      end
   end

   // sequence stage and occurrence count advance on recognised states
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stage <= 3'h0;
         occ_cnt <= 16'h0000;
      end else if (start) begin
         stage <= 3'h0;
         occ_cnt <= 16'h0000;
      end else if (act && fsm == S_PRE) begin
         if (seq_hit) begin
            stage <= stage + 3'h1;
         end
         if (trig_cand) begin
            occ_cnt <= occ_cnt + 16'h0001;
         end
      end
   end

   // acquisition sequencer
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fsm <= S_IDLE;
         triggered <= 1'b0;
      end else if (start) begin
         fsm <= S_PRE;
         triggered <= 1'b0;
      end else begin
         unique case (fsm)
            S_IDLE: begin
               fsm <= S_IDLE;
            end
            S_PRE: begin
               if (trig_now) begin
                  triggered <= 1'b1;
                  // before: record ends on the trigger state
                  fsm <= (mode == MODE_BEFORE) ? S_DONE : S_POST;
               end
            end
            S_POST: begin
               if (post_end) begin
                  fsm <= S_DONE;
               end
            end
            S_DONE: begin
               fsm <= S_DONE;
            end
         endcase
      end
   end

   assign complete = (fsm == S_DONE);

   // write pointer, wrap flag and post-trigger count
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ptr <= '0;
         wrapped <= 1'b0;
         post_cnt <= '0;
      end else if (start) begin
         ptr <= '0;
         wrapped <= 1'b0;
         post_cnt <= '0;
      end else if (do_store) begin
         ptr <= ptr + 1'b1;
         if (ptr == `MEM_AW'(`MEM_DEPTH - 1)) begin
            wrapped <= 1'b1;
         end
         if (fsm == S_POST || trig_now) begin
            post_cnt <= post_cnt + 1'b1;
         end
      end
   end

   // trace memory has no reset; only written slots are meaningful
   always_ff @(posedge clock) begin
      if (do_store) begin
         mem[ptr] <= 32'(state_in);
      end
   end
endmodule
`default_nettype wire

// ===== design/ttq_defines.svh
// constants of the trace trigger and window qualifier: offsets, fields,
// reset values and sizes; assumes byte addressing on the register bus
`ifndef TTQ_DEFINES_SVH
`define TTQ_DEFINES_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_OCC 8'h04
`define OFS_STAT 8'h08
`define OFS_MIDX 8'h0C
`define OFS_MDATA 8'h10
`define OFS_QUAL 8'h40
// control fields
`define CTRL_START 0
`define CTRL_MODE_LSB 1
`define CTRL_WIN 3
`define CTRL_SEQ_LSB 4
// status fields
`define STAT_RUN 0
`define STAT_TRIG 1
`define STAT_DONE 2
`define STAT_WIN 3
`define STAT_WRAP 4
`define STAT_STAGE_LSB 5
`define STAT_PTR_LSB 8
// reset values: any state matches, one occurrence
`define RST_QLO 32'h00000000
`define RST_QHI 32'hFFFFFFFF
`define RST_OCC 16'h0001
// qualifier term slots
`define NUM_TERMS 10
`define TERM_TRIG 0
`define TERM_STORE 1
`define TERM_EN 2
`define TERM_DIS 3
`define TERM_SEQ0 4
// sequence limits without and with windowing
`define SEQ_MAX 3'h6
`define SEQ_MAX_WIN 3'h3
// trace memory size
`define MEM_DEPTH 64
`define MEM_AW 6
`endif

// ===== design/ttq_pkg.sv
// types shared by the qualifier and its comparators
// assumes nothing of its surroundings
package ttq_pkg;
   // one emulation bus state as traced
   typedef struct packed {
      logic [7:0] status; // bus cycle status
      logic [7:0] data; // data bus
      logic [15:0] addr; // address bus
   } state_s;
   // one qualifier term: inclusive low and high bounds per field
   typedef struct packed {
      logic [31:0] lo; // low bounds, packed like state_s
      logic [31:0] hi; // high bounds, packed like state_s
   } qual_s;
   // where the trigger sits in the record
   typedef enum logic [1:0] {
      MODE_AFTER = 2'h0,
      MODE_ABOUT = 2'h1,
      MODE_BEFORE = 2'h2
   } mode_e;
   // acquisition sequencer, one-hot
   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_PRE = 4'h2,
      S_POST = 4'h4,
      S_DONE = 4'h8
   } acq_e;
endpackage

// ===== dv/bus_state_source.sv
// model of the traced target bus: one state per send call
// assumes the bench calls send only after reset is released
`timescale 1ns/1ps
`default_nettype none
module bus_state_source import ttq_pkg::*; (
   input wire logic clock, // system clock
   output logic state_valid, // one-cycle state strobe
   output state_s state_in // traced bus state
);
   // quiet bus until the first state
   initial begin
      state_valid = 1'b0;
      state_in = '0;
   end
   // one state for one cycle, then gap idle cycles; the bus shows
   // the inverse afterwards so a stale state never looks fresh
   task automatic send(input state_s s, input int gap);
      @(posedge clock);
      state_valid <= 1'b1;
      state_in <= s;
      @(posedge clock);
      state_valid <= 1'b0;
      state_in <= ~s;
      repeat (gap) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench of the trace trigger and window qualifier
// assumes the design, its package and defines, and the bus model
`timescale 1ns/1ps
`default_nettype none
`include "ttq_defines.svh"
module tb import ttq_pkg::*;;
   logic clock, nrst, read, write, waitrequest; // clock, reset, bus
   logic state_valid, triggered, complete; // trace side
   logic [7:0] address; // bus address
   logic [3:0] byteenable; // bus lanes, always all
   logic [31:0] writedata, readdata, rd; // bus data, last read
   state_s state_in; // traced state
   int err_count = 0; // mismatches
   int n_compared = 0; // comparisons
   int cycles = 0; // run length guard
   trace_trigger_window_qualifier u_trace_trigger_window_qualifier (
      .clock(clock), .nrst(nrst), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .state_valid(state_valid), .state_in(state_in),
      .triggered(triggered), .complete(complete));
   bus_state_source u_bus_state_source (.clock(clock),
      .state_valid(state_valid), .state_in(state_in));
   // 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // cut a hang short; the whole run needs a few hundred cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         end_of_test;
      end
   end
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one bus transfer; held until the stall drops, no fixed latency
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge clock); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   // one traced state with the given address, data and status zero
   task automatic put(input logic [15:0] a, input int g);
      u_bus_state_source.send({16'h0000, a}, g);
   endtask
   // term slot n: address range, any data and status
   task automatic term(input int n, input logic [15:0] lo, hi);
      bus(1'b1, `OFS_QUAL + 8'(8 * n), {16'h0000, lo});
      bus(1'b1, `OFS_QUAL + 8'(8 * n + 4), {16'hFFFF, hi});
   endtask
   task automatic start(input logic [2:0] sq, input logic win,
         input logic [1:0] md);
      bus(1'b1, `OFS_CTRL, {25'h0, sq, win, md, 1'b1});
   endtask
   // flags are looked at mid-cycle, after the edge has landed
   task automatic flags(input logic t, input logic c);
      @(negedge clock);
      chk({30'h0, triggered, complete}, {30'h0, t, c});
   endtask
   task automatic mem(input logic [5:0] i, input logic [15:0] a);
      bus(1'b1, `OFS_MIDX, {26'h0, i});
      bus(1'b0, `OFS_MDATA, 32'h0);
      chk(rd, {16'h0000, a});
   endtask
   // reset values and an unmapped read
   task automatic t_reset;
      bus(1'b0, `OFS_OCC, 32'h0);
      chk(rd, 32'h00000001);
      bus(1'b0, `OFS_QUAL + 8'h04, 32'h0);
      chk(rd, 32'hFFFFFFFF);
      bus(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h00000000);
   endtask
   // default spec: first state triggers, 64 stores finish
   task automatic t_after;
      start(3'h0, 1'b0, MODE_AFTER);
      put(16'h0500, 0);
      flags(1'b1, 1'b0);
      repeat (62) put(16'h0600, 0);
      flags(1'b1, 1'b0);
      put(16'h0700, 0);
      flags(1'b1, 1'b1);
      mem(6'h00, 16'h0500);
      mem(6'h3F, 16'h0700);
      // idle, triggered, complete, window open, wrapped, pointer back at 0
      bus(1'b0, `OFS_STAT, 32'h0);
      chk(rd, 32'h0000001E);
   endtask
   // second match of the trigger term fires; start clears flags
   task automatic t_occurs;
      term(0, 16'h1000, 16'h1000);
      bus(1'b1, `OFS_OCC, 32'h2);
      start(3'h0, 1'b0, MODE_AFTER);
      flags(1'b0, 1'b0);
      put(16'h1000, 0);
      put(16'h1001, 0);
      flags(1'b0, 1'b0);
      put(16'h1000, 2);
      flags(1'b1, 1'b0);
      bus(1'b1, `OFS_OCC, 32'h1);
   endtask
   // record ends at the trigger
   task automatic t_before;
      start(3'h0, 1'b0, MODE_BEFORE);
      for (int i = 0; i < 5; i++) put(16'h0800 + 16'(i), 0);
      put(16'h1000, 0);
      flags(1'b1, 1'b1);
      mem(6'h00, 16'h0800);
      mem(6'h05, 16'h1000);
      // control reads back the before placement, no window, no sequence
      bus(1'b0, `OFS_CTRL, 32'h0);
      chk(rd, 32'h00000004);
   endtask
   // trigger in the middle: 32 stores from the trigger on
   task automatic t_about;
      start(3'h0, 1'b0, MODE_ABOUT);
      put(16'h0900, 0);
      put(16'h1000, 0);
      repeat (30) put(16'h0A00, 0);
      flags(1'b1, 1'b0);
      put(16'h0A00, 0);
      flags(1'b1, 1'b1);
      mem(6'h00, 16'h0900);
      mem(6'h01, 16'h1000);
   endtask
   // window opened, closed and reopened with a storage range
   task automatic t_window;
      logic [15:0] w [6] = '{16'h1001, 16'h5000, 16'h3000,
         16'h1002, 16'h2000, 16'h1003};
      term(1, 16'h1000, 16'h1FFF);
      term(2, 16'h2000, 16'h2000);
      term(3, 16'h3000, 16'h3000);
      start(3'h0, 1'b1, MODE_AFTER);
      put(16'h1000, 0);
      flags(1'b0, 1'b0);
      put(16'h2000, 0);
      flags(1'b0, 1'b0);
      put(16'h1000, 0);
      flags(1'b1, 1'b0);
      foreach (w[i]) put(w[i], 0);
      bus(1'b0, `OFS_STAT, 32'h0);
      chk({26'h0, rd[13:8]}, 32'h3);
      chk({31'h0, rd[3]}, 32'h1);
      mem(6'h01, 16'h1001);
      mem(6'h02, 16'h1003);
      start(3'h0, 1'b1, MODE_AFTER);
      bus(1'b0, `OFS_STAT, 32'h0);
      chk({31'h0, rd[3]}, 32'h0);
   endtask
   // one sequence term must come before the trigger counts
   task automatic t_seq;
      term(4, 16'h4000, 16'h4000);
      start(3'h1, 1'b0, MODE_AFTER);
      put(16'h1000, 0);
      flags(1'b0, 1'b0);
      put(16'h4000, 0);
      put(16'h1000, 3);
      flags(1'b1, 1'b0);
   endtask
   // reset for 20 cycles, then the scenarios in turn
   initial begin
      nrst = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      byteenable = 4'hF;
      writedata = 32'h0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      t_reset;
      t_after;
      t_occurs;
      t_before;
      t_about;
      t_window;
      t_seq;
      end_of_test;
   end
endmodule
`default_nettype wire

// ===== dv/ttq_checker_sva.sv
// checker: port timing of the trace trigger and window qualifier
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "ttq_defines.svh"
module ttq_checker import ttq_pkg::*; (
   input wire logic clock, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic [7:0] address, // bus byte address
   input wire logic read, // bus read
   input wire logic write, // bus write
   input wire logic [3:0] byteenable, // bus byte lanes
   input wire logic [31:0] writedata, // bus write data
   input wire logic waitrequest, // bus stall
   input wire logic state_valid, // traced state strobe
   input wire logic triggered, // trigger found
   input wire logic complete // record finished
);
   logic start_q; // a start write was taken at the last edge
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // flags may only clear after a taken start, so remember one
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         start_q <= 1'b0;
      end else begin
         start_q <= write && !waitrequest && byteenable[0] &&
            address == `OFS_CTRL && writedata[`CTRL_START];
      end
   end
   // one stall cycle, then the answer
   sequence s_answer;
      waitrequest ##1 !waitrequest;
   endsequence
   AST_BUS_READ: assert property ($rose(read) |-> s_answer)
      else $error("read not answered after one stall");
   AST_BUS_WRITE: assert property ($rose(write) |-> s_answer)
      else $error("write not answered after one stall");
   AST_TRIG_CAUSE: assert property ($rose(triggered) |->
      $past(state_valid))
      else $error("trigger rose without a traced state");
   AST_DONE_CAUSE: assert property ($rose(complete) |->
      $past(state_valid))
      else $error("record finished without a traced state");
   AST_DONE_TRIG: assert property (complete |-> triggered)
      else $error("record finished with no trigger");
   AST_TRIG_CLEAR: assert property ($fell(triggered) |-> start_q)
      else $error("trigger flag cleared without a start");
   AST_DONE_CLEAR: assert property ($fell(complete) |-> start_q)
      else $error("finished flag cleared without a start");
   AST_FLAGS_STILL: assert property ((!state_valid &&
      !(write && !waitrequest)) |=> $stable({triggered, complete}))
      else $error("flags moved with no state and no write");
endmodule
bind trace_trigger_window_qualifier ttq_checker u_ttq_checker (
   .clock(clock), .nrst(nrst), .address(address), .read(read),
   .write(write), .byteenable(byteenable), .writedata(writedata),
   .waitrequest(waitrequest), .state_valid(state_valid),
   .triggered(triggered), .complete(complete));
`default_nettype wire
